// *** common/status_defines.vh ***
// constants shared by the master status block and its scenario bench
`ifndef STATUS_DEFINES_VH
`define STATUS_DEFINES_VH

// node address space: nodes 0 .. 126
`define NODE_COUNT        127
`define NODE_ID_W         7
`define NODE_CNT_W        8

// host controller mode codes
`define HOST_MODE_W       2
`define HOST_MODE_RUN     2'h1
`define HOST_MODE_PROGRAM 2'h0
`define HOST_MODE_FAULT   2'h2

// per-node event kinds
`define EVT_KIND_W        3
`define EVT_ONLINE        3'h0
`define EVT_OFFLINE       3'h1
`define EVT_XCHG_START    3'h2
`define EVT_XCHG_STOP     3'h3
`define EVT_ALARM_RAISE   3'h4
`define EVT_ALARM_UNLOAD  3'h5
`define EVT_DIAG_RAISE    3'h6
`define EVT_DIAG_UNLOAD   3'h7

// widths and reset values
`define SIG_W             32
`define SIG_RESET         32'h0000_0000
`define TIMEOUT_W         16
`define TIMEOUT_VALUE     16'h0000

`endif

// *** hdl/node_counter.v ***
// population count of a per-node bitmap
`timescale 1ns/1ps
`default_nettype none

module node_counter #(
   parameter NODES = 127,
   parameter CNT_W = 8
) (
   input  wire [NODES-1:0] map_i,
   output reg  [CNT_W-1:0] count_o
);

   integer k;

   // plain adder chain; count width covers all nodes
   always @* begin
      count_o = {CNT_W{1'b0}};
      for (k = 0; k < NODES; k = k + 1) begin
         count_o = count_o + {{(CNT_W-1){1'b0}}, map_i[k]};
      end
   end

endmodule // node_counter

`default_nettype wire

// *** hdl/master_status_block.v ***
// status word block presented by the fieldbus master to its host controller
// Summary of operation
// R1 - host run flag reads one while the host controller is in run mode
// R2 - host run flag reads zero in program or fault mode
// R3 - redundancy configured flag: one when redundancy enabled, zero standalone
// R4 - redundancy role flag: one while active role held, zero on standby
// R5 - signature value identifies the configuration currently executing
// R6 - count equals nodes online and exchanging data with the master
// R7 - online bitmap: bit n one while node n is present on the network
// R8 - exchange bitmap: bit n one only while node n online and exchanging
// R9 - alarm bitmap: bit n one while node n holds an alarm to unload
// R10 - diagnostics bitmap: bit n one while node n holds diagnostics to unload
// R11 - all bitmaps clear at reset; changeover timeout always reads zero
`include "status_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module master_status_block #(
   parameter NODES = `NODE_COUNT,
   parameter ID_W  = `NODE_ID_W,
   parameter CNT_W = `NODE_CNT_W,
   parameter SIG_W = `SIG_W,
   parameter TO_W  = `TIMEOUT_W
) (
   input  wire                    clk_i,
   input  wire                    rstn_i,
   // host controller mode, from the host link logic
   input  wire [`HOST_MODE_W-1:0] host_mode_i,
   // redundancy configuration and role from the redundancy manager
   input  wire                    redundancy_enable_i,
   input  wire                    redundancy_role_i,
   // configuration signature load strobe
   input  wire                    config_sig_load_i,
   input  wire [SIG_W-1:0]        config_sig_i,
   // per-node events from the protocol engine
   input  wire                    node_evt_valid_i,
   input  wire [ID_W-1:0]         node_evt_id_i,
   input  wire [`EVT_KIND_W-1:0]  node_evt_kind_i,
   // status outputs
   output reg                     host_run_flag_o,
   output reg                     redundancy_configured_o,
   output reg                     redundancy_role_active_o,
   output reg  [SIG_W-1:0]        config_signature_o,
   output reg  [CNT_W-1:0]        exchanging_node_count_o,
   output reg  [TO_W-1:0]         changeover_timeout_o,
   output reg  [NODES-1:0]        node_online_map_o,
   output reg  [NODES-1:0]        node_exchange_map_o,
   output reg  [NODES-1:0]        node_alarm_map_o,
   output reg  [NODES-1:0]        node_diag_map_o
);

   // ------------------------------------------------------------
   // event decode
   // ------------------------------------------------------------

   // one-hot node select; out-of-range ids select nothing
   function [NODES-1:0] node_select;
      input [ID_W-1:0] id;
      input            valid;
      integer          j;
      begin
         node_select = {NODES{1'b0}};
         for (j = 0; j < NODES; j = j + 1) begin
            if (valid && (id == j[ID_W-1:0])) begin
               node_select[j] = 1'b1;
            end
         end
      end
   endfunction

   // kind match, used once per event type
   function kind_is;
      input [`EVT_KIND_W-1:0] kind;
      input [`EVT_KIND_W-1:0] want;
      begin
         kind_is = (kind == want);
      end
   endfunction

   wire [NODES-1:0] sel;
   wire             ev_online;
   wire             ev_offline;
   wire             ev_xstart;
   wire             ev_xstop;
   wire             ev_araise;
   wire             ev_aunload;
   wire             ev_draise;
   wire             ev_dunload;

   assign sel        = node_select(node_evt_id_i, node_evt_valid_i);
   assign ev_online  = kind_is(node_evt_kind_i, `EVT_ONLINE);
   assign ev_offline = kind_is(node_evt_kind_i, `EVT_OFFLINE);
   assign ev_xstart  = kind_is(node_evt_kind_i, `EVT_XCHG_START);
   assign ev_xstop   = kind_is(node_evt_kind_i, `EVT_XCHG_STOP);
   assign ev_araise  = kind_is(node_evt_kind_i, `EVT_ALARM_RAISE);
   assign ev_aunload = kind_is(node_evt_kind_i, `EVT_ALARM_UNLOAD);
   assign ev_draise  = kind_is(node_evt_kind_i, `EVT_DIAG_RAISE);
   assign ev_dunload = kind_is(node_evt_kind_i, `EVT_DIAG_UNLOAD);

   // ------------------------------------------------------------
   // per-node bitmaps
   // ------------------------------------------------------------

   wire [NODES-1:0] online_d;
   wire [NODES-1:0] exchange_d;
   wire [NODES-1:0] alarm_d;
   wire [NODES-1:0] diag_d;

   genvar n;
   generate
      for (n = 0; n < NODES; n = n + 1) begin : g_node
         // next state kept local so each vector bit has a single driver
         reg online_bit_d;
         reg exchange_bit_d;
         reg alarm_bit_d;
         reg diag_bit_d;
         always @* begin
            online_bit_d   = node_online_map_o[n];
            exchange_bit_d = node_exchange_map_o[n];
            alarm_bit_d    = node_alarm_map_o[n];
            diag_bit_d     = node_diag_map_o[n];
            if (sel[n]) begin
               if (ev_online) begin
                  online_bit_d = 1'b1; // [R7]
               end
               if (ev_offline) begin
                  online_bit_d   = 1'b0; // [R7]
                  // a lost node cannot keep exchanging
                  exchange_bit_d = 1'b0; // [R8]
               end
               // start is ignored for a node not online
               if (ev_xstart && node_online_map_o[n]) begin
                  exchange_bit_d = 1'b1; // [R8]
               end
               if (ev_xstop) begin
                  exchange_bit_d = 1'b0; // [R8]
               end
               // pending items stay until unloaded, even offline
               if (ev_araise) begin
                  alarm_bit_d = 1'b1; // [R9]
               end
               if (ev_aunload) begin
                  alarm_bit_d = 1'b0; // [R9]
               end
               if (ev_draise) begin
                  diag_bit_d = 1'b1; // [R10]
               end
               if (ev_dunload) begin
                  diag_bit_d = 1'b0; // [R10]
               end
            end
         end
         assign online_d[n]   = online_bit_d;
         assign exchange_d[n] = exchange_bit_d;
         assign alarm_d[n]    = alarm_bit_d;
         assign diag_d[n]     = diag_bit_d;
      end
   endgenerate

   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         node_online_map_o   <= {NODES{1'b0}}; // [R11]
         node_exchange_map_o <= {NODES{1'b0}}; // [R11]
         node_alarm_map_o    <= {NODES{1'b0}}; // [R11]
         node_diag_map_o     <= {NODES{1'b0}}; // [R11]
      end else begin
         node_online_map_o   <= online_d;
         node_exchange_map_o <= exchange_d;
         node_alarm_map_o    <= alarm_d;
         node_diag_map_o     <= diag_d;
      end
   end

   // ------------------------------------------------------------
   // exchanging node count
   // ------------------------------------------------------------

   wire [CNT_W-1:0] count_d;

   // counted from next map state so count and map move together
   node_counter #(
      .NODES (NODES),
      .CNT_W (CNT_W)
   ) i_node_counter (
      .map_i   (exchange_d),
      .count_o (count_d)
   );

   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         exchanging_node_count_o <= {CNT_W{1'b0}};
      end else begin
         exchanging_node_count_o <= count_d; // [R6]
      end
   end

   // ------------------------------------------------------------
   // controller, redundancy and configuration status
   // ------------------------------------------------------------

   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         host_run_flag_o          <= 1'b0;
         redundancy_configured_o  <= 1'b0;
         redundancy_role_active_o <= 1'b0;
         config_signature_o       <= `SIG_RESET;
         changeover_timeout_o     <= `TIMEOUT_VALUE;
      end else begin
         // any code other than run, fault included, reads zero
         host_run_flag_o <= (host_mode_i == `HOST_MODE_RUN); // [R1] [R2]
         redundancy_configured_o <= redundancy_enable_i; // [R3]
         // standalone module has no role to hold
         redundancy_role_active_o <= redundancy_enable_i & redundancy_role_i; // [R4]
         if (config_sig_load_i) begin
            config_signature_o <= config_sig_i; // [R5]
         end
         // field carries no function
         changeover_timeout_o <= `TIMEOUT_VALUE; // [R11]
      end
   end

endmodule // master_status_block

`default_nettype wire

// *** test/status_monitor.sv ***
// concurrent checks on the master status block ports
`timescale 1ns/1ps
`default_nettype none
module status_monitor (
   input wire logic         clk_i,
   input wire logic         rstn_i,
   input wire logic [1:0]   host_mode_i,
   input wire logic         redundancy_enable_i,
   input wire logic         redundancy_role_i,
   input wire logic         config_sig_load_i,
   input wire logic [31:0]  config_sig_i,
   input wire logic         node_evt_valid_i,
   input wire logic [6:0]   node_evt_id_i,
   input wire logic [2:0]   node_evt_kind_i,
   input wire logic         host_run_flag_o,
   input wire logic         redundancy_configured_o,
   input wire logic         redundancy_role_active_o,
   input wire logic [31:0]  config_signature_o,
   input wire logic [7:0]   exchanging_node_count_o,
   input wire logic [15:0]  changeover_timeout_o,
   input wire logic [126:0] node_online_map_o,
   input wire logic [126:0] node_exchange_map_o,
   input wire logic [126:0] node_alarm_map_o,
   input wire logic [126:0] node_diag_map_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   // id 127 selects no node
   wire ev_ok = node_evt_valid_i && node_evt_id_i != 7'h7F;
   wire [1:0] grp = node_evt_kind_i[2:1];
   AST_RUN_FLAG: assert property ($past(rstn_i) |-> host_run_flag_o == ($past(host_mode_i) == 2'h1)) else $error("run flag wrong");
   AST_RED_CFG: assert property ($past(rstn_i) |-> redundancy_configured_o == $past(redundancy_enable_i)) else $error("redundancy flag wrong");
   AST_ROLE: assert property ($past(rstn_i) |-> redundancy_role_active_o == $past(redundancy_enable_i && redundancy_role_i)) else $error("role flag wrong");
   AST_SIG_LOAD: assert property (config_sig_load_i |=> config_signature_o == $past(config_sig_i)) else $error("signature not loaded");
   AST_SIG_HOLD: assert property (!config_sig_load_i |=> $stable(config_signature_o)) else $error("signature moved");
   AST_COUNT: assert property (exchanging_node_count_o == $countones(node_exchange_map_o)) else $error("count wrong");
   AST_ONLINE_EVT: assert property (ev_ok && grp == 2'h0 |=> node_online_map_o[$past(node_evt_id_i)] == !$past(node_evt_kind_i[0])) else $error("online bit wrong");
   AST_XCHG_SUB: assert property ((node_exchange_map_o & ~node_online_map_o) == 127'h0) else $error("exchange without online");
   AST_XCHG_REFUSE: assert property (ev_ok && node_evt_kind_i == 3'h2 && !node_online_map_o[node_evt_id_i] |=> !node_exchange_map_o[$past(node_evt_id_i)]) else $error("offline node exchanging");
   AST_ALARM_EVT: assert property (ev_ok && grp == 2'h2 |=> node_alarm_map_o[$past(node_evt_id_i)] == !$past(node_evt_kind_i[0])) else $error("alarm bit wrong");
   AST_DIAG_EVT: assert property (ev_ok && grp == 2'h3 |=> node_diag_map_o[$past(node_evt_id_i)] == !$past(node_evt_kind_i[0])) else $error("diag bit wrong");
   AST_TIMEOUT: assert property (changeover_timeout_o == 16'h0000) else $error("timeout not zero");
   // reset clearing is checked while reset is low, so no disable here
   AST_RESET_CLR: assert property (disable iff (1'b0) !rstn_i |-> (node_online_map_o | node_exchange_map_o | node_alarm_map_o | node_diag_map_o) == 127'h0) else $error("maps not cleared");
   cover property (ev_ok && node_evt_kind_i == 3'h2);
   cover property (config_sig_load_i);
   cover property (redundancy_role_active_o);
endmodule // status_monitor
bind master_status_block status_monitor i_status_monitor (
   .clk_i                    (clk_i),
   .rstn_i                   (rstn_i),
   .host_mode_i              (host_mode_i),
   .redundancy_enable_i      (redundancy_enable_i),
   .redundancy_role_i        (redundancy_role_i),
   .config_sig_load_i        (config_sig_load_i),
   .config_sig_i             (config_sig_i),
   .node_evt_valid_i         (node_evt_valid_i),
   .node_evt_id_i            (node_evt_id_i),
   .node_evt_kind_i          (node_evt_kind_i),
   .host_run_flag_o          (host_run_flag_o),
   .redundancy_configured_o  (redundancy_configured_o),
   .redundancy_role_active_o (redundancy_role_active_o),
   .config_signature_o       (config_signature_o),
   .exchanging_node_count_o  (exchanging_node_count_o),
   .changeover_timeout_o     (changeover_timeout_o),
   .node_online_map_o        (node_online_map_o),
   .node_exchange_map_o      (node_exchange_map_o),
   .node_alarm_map_o         (node_alarm_map_o),
   .node_diag_map_o          (node_diag_map_o)
);
`default_nettype wire

// *** test/host_ctrl_model.sv ***
// host controller model driving its run/program/fault mode
`timescale 1ns/1ps
`default_nettype none
module host_ctrl_model (
   input wire logic  clk_i,
   output logic [1:0] host_mode_o
);
   initial host_mode_o = 2'h0;
   // mode changes just after an edge, like the bench stimulus
   task automatic set_mode(input logic [1:0] m);
      @(posedge clk_i);
      #1 host_mode_o = m;
   endtask
endmodule // host_ctrl_model
`default_nettype wire

// *** test/fieldbus_master_status_block_tb_top.sv ***
// scenario bench for the master status block
`include "status_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module fieldbus_master_status_block_tb_top;
   // reset starts high so its drop is a real edge for the async clear
   logic clk_i = 1'b0, rstn_i = 1'b1, ld = 1'b0, en = 1'b0, rl = 1'b0, ev_v = 1'b0;
   logic [31:0]  sig = 32'h0;
   logic [6:0]   ev_id = 7'h0;
   logic [2:0]   ev_k = 3'h0;
   wire [1:0]    mode;
   wire          run, cfg, role;
   wire [31:0]   sig_o;
   wire [7:0]    cnt;
   wire [15:0]   tmo;
   wire [126:0]  onl, xch, alm, dia;
   int failures = 0, cmp_count = 0, cyc = 0;
   always #12.5 clk_i = ~clk_i;
   host_ctrl_model i_host_ctrl_model (.clk_i(clk_i), .host_mode_o(mode));
   master_status_block i_master_status_block (.clk_i(clk_i), .rstn_i(rstn_i),
      .host_mode_i(mode), .redundancy_enable_i(en), .redundancy_role_i(rl),
      .config_sig_load_i(ld), .config_sig_i(sig), .node_evt_valid_i(ev_v),
      .node_evt_id_i(ev_id), .node_evt_kind_i(ev_k), .host_run_flag_o(run),
      .redundancy_configured_o(cfg), .redundancy_role_active_o(role),
      .config_signature_o(sig_o), .exchanging_node_count_o(cnt),
      .changeover_timeout_o(tmo), .node_online_map_o(onl), .node_exchange_map_o(xch),
      .node_alarm_map_o(alm), .node_diag_map_o(dia));
   task automatic final_report;
      $display("failures %0d comparisons %0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // hang guard, far above the 44 cycles needed
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 2000) begin
         failures++;
         final_report;
      end
   end
   task automatic chk_bit(input logic g, input logic e);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %0t bit got %b exp %b", $time, g, e);
      end
   endtask
   task automatic chk_vec(input logic [127:0] g, input logic [127:0] e);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %0t value got %h exp %h", $time, g, e);
      end
   endtask
   task automatic tick; @(posedge clk_i); #1; endtask
   // valid stays up so events run back to back
   task automatic ev(input logic [6:0] id, input logic [2:0] k);
      tick; ev_v = 1'b1; ev_id = id; ev_k = k;
   endtask
   task automatic ev_end; tick; ev_v = 1'b0; endtask
   task automatic t_clear;
      chk_vec(128'(onl | xch | alm | dia), 128'h0);
      chk_vec(128'(tmo), 128'h0);
   endtask
   task automatic t_mode;
      for (int m = 0; m < 4; m++) begin
         i_host_ctrl_model.set_mode(2'(m));
         tick;
         chk_bit(run, m == 1);
      end
   endtask
   task automatic t_red;
      for (int i = 0; i < 4; i++) begin
         tick; {en, rl} = 2'(i);
         tick;
         chk_bit(cfg, i >= 2);
         chk_bit(role, i == 3);
      end
   endtask
   task automatic t_sig;
      tick; ld = 1'b1; sig = 32'hA5C3_0F1E;
      tick; ld = 1'b0; sig = 32'h1234_5678;
      chk_vec(128'(sig_o), 128'hA5C3_0F1E);
      tick; tick;
      chk_vec(128'(sig_o), 128'hA5C3_0F1E);
   endtask
   task automatic t_nodes;
      ev(7'h00, `EVT_ONLINE); ev(7'h7E, `EVT_ONLINE); ev(7'h7E, `EVT_XCHG_START);
      ev(7'h00, `EVT_XCHG_START); ev(7'h05, `EVT_XCHG_START); ev(7'h7F, `EVT_ONLINE); ev_end;
      chk_vec(128'(onl), (128'h1 << 126) | 128'h1);
      chk_vec(128'(xch), (128'h1 << 126) | 128'h1);
      chk_vec(128'(cnt), 128'h2);
      ev(7'h7E, `EVT_OFFLINE); ev_end;
      chk_vec(128'(onl), 128'h1);
      chk_vec(128'(xch), 128'h1);
      chk_vec(128'(cnt), 128'h1);
      ev(7'h00, `EVT_XCHG_STOP); ev_end;
      chk_vec(128'(onl), 128'h1);
      chk_vec(128'(xch), 128'h0);
      chk_vec(128'(cnt), 128'h0);
   endtask
   task automatic t_pending;
      ev(7'h03, `EVT_ALARM_RAISE); ev(7'h03, `EVT_DIAG_RAISE); ev(7'h03, `EVT_OFFLINE); ev_end;
      chk_vec(128'(alm), 128'h8);
      chk_vec(128'(dia), 128'h8);
      ev(7'h03, `EVT_ALARM_UNLOAD); ev_end;
      chk_vec(128'(alm), 128'h0);
      chk_vec(128'(dia), 128'h8);
      ev(7'h03, `EVT_DIAG_UNLOAD); ev_end;
      chk_vec(128'(dia), 128'h0);
   endtask
   task automatic t_rereset;
      ev(7'h09, `EVT_ALARM_RAISE); ev_end;
      rstn_i = 1'b0;
      tick;
      t_clear;
      rstn_i = 1'b1;
   endtask
   initial begin
      #1 rstn_i = 1'b0;
      repeat (2) tick;
      t_clear;
      rstn_i = 1'b1;
      t_mode; t_red; t_sig; t_nodes; t_pending; t_rereset;
      final_report;
   end
endmodule // fieldbus_master_status_block_tb_top
`default_nettype wire
